// ### pkg/ext_bus_pkg.sv
/*
 Shared constants and carrier types of the external memory bus port.
 Assumes a single 200 MHz clock and a plain register port.
*/
package ext_bus_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] BCR_OFS  = 4'h0;
   localparam logic [3:0] OMR_OFS  = 4'h1;
   localparam logic [3:0] DCR_OFS  = 4'h2;
   localparam logic [3:0] ATTR_OFS = 4'h3;
   localparam logic [3:0] STAT_OFS = 4'h4;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int WS_LSB      = 0;
   localparam int WS_W        = 5;
   localparam int RHOLD_BIT   = 5;
   localparam int LHOLD_BIT   = 6;
   localparam int ASYNC_BIT   = 0;
   localparam int BME_BIT     = 0;
   localparam logic [6:0] BCR_RST  = 7'h1F;
   localparam logic       OMR_RST  = 1'h0;
   localparam logic       DCR_RST  = 1'h0;
   localparam logic [3:0] ATTR_RST = 4'h0;
   // ---------------------------------------------------------------
   // Timing: four fast clocks per core output clock
   // ---------------------------------------------------------------
   localparam int PH_W = 2;
   localparam logic [1:0] PH_LAST = 2'h3;
   localparam int MAX_WS = 31;
   // ---------------------------------------------------------------
   // Access kinds and carriers
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {K_SRAM, K_SSRAM, K_DRAM} kind_t;
   typedef struct packed {
      logic [23:0] addr;
      logic [23:0] wdata;
      logic        write;
      logic        rmw;
      kind_t       kind;
      logic [3:0]  attr;
   } req_t;
   typedef struct packed {
      logic [3:0]  aa;
      logic        rd_n;
      logic        wr_n;
      logic        bs_n;
      logic        cas_n;
   } strobe_t;
endpackage

// ### src/ext_bus_port.sv
/*
 External memory bus port: address/data drive, strobes, wait states,
 transfer acknowledge, bus arbitration, parking and lock.
 Assumes pins are resolved by the bench from the active-low enables
 and that the arbiter and core requests run off CLOCK.
*/
// Strobed register access and the address map are this design's own decisions.
// Functional notes
// - Address driven only as master; floats otherwise and in reset; holds when idle.
// - Data bus floats when not master, when idle and in reset.
// - Four attribute lines with programmable polarity; float in reset.
// - Read and write strobes active low as master; float otherwise.
// - Acknowledge ignored unless master with a bus cycle running.
// - Acknowledge sync or async, chosen by a mode register bit.
// - Cycle ends one core period after acknowledge; negated acknowledge stretches.
// - Wait states are the larger of programmed and acknowledge counts; here zero programmed waits and DRAM accesses ignore acknowledge.
// - Acknowledge tied low with zero programmed waits gives zero waits.
// - Bus request follows core or DMA external need and the request hold bit.
// - Request hold bit keeps bus request asserted.
// - Reset negates request, enters slave state, ignores grant.
// - After grant, wait for busy negated, then assert busy.
// - Grant negated releases mastership at end of current cycle.
// - Master may park, keeping busy asserted without activity.
// - Busy released by driving high then floating.
// - Lock asserted from read-modify-write start to end of its write.
// - Lock hold bit keeps lock asserted.
// - Bus strobe low half a core cycle at each cycle start.
// - Column strobe driven as master; floats when slave unless enabled.
// - Bus clock toggles only on synchronous accesses, quarter cycle early.
// - Programmed wait count reaches thirty-one.
module ext_bus_port #(
   parameter int WS_BITS = 5
) (
   input  wire logic                    CLOCK,
   input  wire logic                    SYS_RST,
   input  wire logic [3:0]              REG_ADDR,
   input  wire logic [23:0]             REG_WDATA,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   output logic [23:0]                  REG_RDATA,
   input  wire logic                    REQ_VALID,
   input  wire ext_bus_pkg::req_t       REQ,
   output logic                         REQ_READY,
   output logic                         DONE,
   output logic [23:0]                  RDATA,
   output logic                         CORE_CLOCK_OUT,
   output logic [23:0]                  A_OUT,
   output logic                         A_OE_N,
   input  wire logic [23:0]             D_IN,
   output logic [23:0]                  D_OUT,
   output logic                         D_OE_N,
   output ext_bus_pkg::strobe_t         STB_OUT,
   output logic                         STB_OE_N,
   output logic                         CAS_OE_N,
   output logic                         BCLK,
   output logic                         BCLK_OE_N,
   input  wire logic                    TRANSFER_ACK_N,
   output logic                         BUS_REQUEST_N,
   input  wire logic                    BUS_GRANT_N,
   input  wire logic                    BUS_BUSY_N_IN,
   output logic                         BUS_BUSY_N_OUT,
   output logic                         BUS_BUSY_N_OE_N,
   output logic                         BUS_LOCK_N
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [6:0]  bus_control_reg;
   logic        operating_mode_reg;
   logic        dram_control_reg;
   logic [3:0]  attr_pol_reg;
   logic [WS_BITS-1:0] ws_prog;
   logic        request_hold_bit;
   logic        lock_hold_bit;

   assign ws_prog          = bus_control_reg[ext_bus_pkg::WS_LSB +: WS_BITS];
   assign request_hold_bit = bus_control_reg[ext_bus_pkg::RHOLD_BIT];
   assign lock_hold_bit    = bus_control_reg[ext_bus_pkg::LHOLD_BIT];

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         bus_control_reg    <= ext_bus_pkg::BCR_RST;
         operating_mode_reg <= ext_bus_pkg::OMR_RST;
         dram_control_reg   <= ext_bus_pkg::DCR_RST;
         attr_pol_reg       <= ext_bus_pkg::ATTR_RST;
      end else if (REG_WR) begin
         unique case (REG_ADDR)
            ext_bus_pkg::BCR_OFS:  bus_control_reg    <= REG_WDATA[6:0];
            ext_bus_pkg::OMR_OFS:  operating_mode_reg <= REG_WDATA[ext_bus_pkg::ASYNC_BIT];
            ext_bus_pkg::DCR_OFS:  dram_control_reg   <= REG_WDATA[ext_bus_pkg::BME_BIT];
            ext_bus_pkg::ATTR_OFS: attr_pol_reg       <= REG_WDATA[3:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Core clock phases
   // ---------------------------------------------------------------
   logic [ext_bus_pkg::PH_W-1:0] ph_reg;
   logic                         ph_end;
   assign ph_end = (ph_reg == ext_bus_pkg::PH_LAST);

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) ph_reg <= '0;
      else ph_reg <= ph_reg + 2'h1;
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) CORE_CLOCK_OUT <= 1'b0;
      else CORE_CLOCK_OUT <= (ph_reg == 2'h3) || (ph_reg == 2'h0);
   end

   // ---------------------------------------------------------------
   // Pin synchronisers; first stage read only by the second
   // ---------------------------------------------------------------
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic       ack_a_reg;
   logic       ack_n_pin;
   logic       grant;
   logic       busy_ext;

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s1_reg    <= 3'h7;
         s2_reg    <= 3'h7;
         ack_a_reg <= 1'b1;
      end else begin
         s1_reg    <= {TRANSFER_ACK_N, BUS_GRANT_N, BUS_BUSY_N_IN};
         s2_reg    <= s1_reg;
         ack_a_reg <= s2_reg[2];
      end
   end

   // Async mode spends one extra stage for margin on a free-running input
   assign ack_n_pin = operating_mode_reg ? ack_a_reg : s2_reg[2];
   assign grant     = ~s2_reg[1];
   assign busy_ext  = ~s2_reg[0];

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ARB_SLAVE, ARB_WAIT, ARB_MASTER, ARB_RELEASE} arb_t;
   arb_t arb_reg;
   logic master;
   logic cyc_busy;
   logic busy_drive_reg;

   assign master = (arb_reg == ARB_MASTER);

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) arb_reg <= ARB_SLAVE;
      else if (ph_end) begin
         unique case (arb_reg)
            ARB_SLAVE:   if (grant) arb_reg <= ARB_WAIT;
            ARB_WAIT: begin
               if (!grant) arb_reg <= ARB_SLAVE;
               else if (!busy_ext) arb_reg <= ARB_MASTER;
            end
            // Parks while grant stays, whatever the request does
            ARB_MASTER:  if (!grant && !cyc_busy) arb_reg <= ARB_RELEASE;
            ARB_RELEASE: arb_reg <= ARB_SLAVE;
         endcase
      end
   end

   // Busy driven low as master, high for one core cycle on release
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         BUS_BUSY_N_OUT  <= 1'b1;
         BUS_BUSY_N_OE_N <= 1'b1;
         busy_drive_reg  <= 1'b0;
      end else begin
         BUS_BUSY_N_OUT  <= ~master;
         BUS_BUSY_N_OE_N <= ~(master || arb_reg == ARB_RELEASE);
         busy_drive_reg  <= master;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) BUS_REQUEST_N <= 1'b1;
      else BUS_REQUEST_N <= ~(REQ_VALID || request_hold_bit);
   end

   // ---------------------------------------------------------------
   // Bus cycle engine, steps at core cycle ends
   // ---------------------------------------------------------------
   ext_bus_pkg::req_t cur_reg;
   logic [WS_BITS-1:0] wcnt_reg;
   logic               first_reg;
   logic               ack_q_reg;
   logic               finish;
   logic               ws_met;
   logic               lock_reg;

   function automatic logic ack_ok(input logic [WS_BITS-1:0] ws, input logic ack,
                                   input ext_bus_pkg::kind_t k);
      // Zero waits and dynamic memory do not look at acknowledge
      ack_ok = (ws == '0) || ack || (k == ext_bus_pkg::K_DRAM);
   endfunction

   assign ws_met    = (wcnt_reg >= ws_prog);
   assign finish    = cyc_busy && ph_end && ws_met && ack_ok(ws_prog, ack_q_reg, cur_reg.kind);
   assign REQ_READY = master && grant && ph_end && (!cyc_busy || finish);

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cyc_busy  <= 1'b0;
         cur_reg   <= '0;
         wcnt_reg  <= '0;
         first_reg <= 1'b0;
      end else if (ph_end) begin
         if (REQ_VALID && REQ_READY) begin
            cyc_busy  <= 1'b1;
            cur_reg   <= REQ;
            wcnt_reg  <= '0;
            first_reg <= 1'b1;
         end else begin
            if (finish) cyc_busy <= 1'b0;
            if (cyc_busy && !ws_met) wcnt_reg <= wcnt_reg + 1'b1;
            first_reg <= 1'b0;
         end
      end
   end

   // Acknowledge seen at a core cycle end closes the cycle after it
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) ack_q_reg <= 1'b0;
      else if (ph_end) ack_q_reg <= master && cyc_busy && !ack_n_pin && !finish;
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         DONE  <= 1'b0;
         RDATA <= '0;
      end else begin
         DONE <= finish;
         if (finish && !cur_reg.write) RDATA <= D_IN;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) lock_reg <= 1'b0;
      else if (ph_end && REQ_VALID && REQ_READY && REQ.rmw) lock_reg <= 1'b1;
      else if (finish && cur_reg.rmw && cur_reg.write) lock_reg <= 1'b0;
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) BUS_LOCK_N <= 1'b1;
      else BUS_LOCK_N <= ~(lock_reg || lock_hold_bit);
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   logic active;
   logic dram;
   assign active = cyc_busy && master;
   assign dram   = (cur_reg.kind == ext_bus_pkg::K_DRAM);

   // Address holds its last value between cycles to save toggling
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         A_OUT  <= '0;
         A_OE_N <= 1'b1;
      end else begin
         A_OE_N <= ~master;
         if (active) A_OUT <= cur_reg.addr;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         D_OUT  <= '0;
         D_OE_N <= 1'b1;
      end else begin
         D_OE_N <= ~(active && cur_reg.write);
         if (active && cur_reg.write) D_OUT <= cur_reg.wdata;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         STB_OUT  <= '1;
         STB_OE_N <= 1'b1;
         CAS_OE_N <= 1'b1;
      end else begin
         STB_OE_N      <= ~master;
         CAS_OE_N      <= ~(master || dram_control_reg);
         STB_OUT.aa    <= (active ? cur_reg.attr : 4'h0) ^ attr_pol_reg;
         STB_OUT.rd_n  <= ~(active && !cur_reg.write);
         STB_OUT.wr_n  <= ~(active && cur_reg.write);
         STB_OUT.bs_n  <= ~(active && first_reg && ph_reg[1] == 1'b1);
         STB_OUT.cas_n <= ~(active && dram && !first_reg);
      end
   end

   // Bus clock leads the core clock by one fast phase
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         BCLK      <= 1'b0;
         BCLK_OE_N <= 1'b1;
      end else begin
         BCLK_OE_N <= ~master;
         BCLK      <= active && cur_reg.kind == ext_bus_pkg::K_SSRAM &&
                      (ph_reg == 2'h2 || ph_reg == 2'h3);
      end
   end

   // ---------------------------------------------------------------
   // Register read
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) REG_RDATA <= '0;
      else if (REG_RD) begin
         unique case (REG_ADDR)
            ext_bus_pkg::BCR_OFS:  REG_RDATA <= {17'h0, bus_control_reg};
            ext_bus_pkg::OMR_OFS:  REG_RDATA <= {23'h0, operating_mode_reg};
            ext_bus_pkg::DCR_OFS:  REG_RDATA <= {23'h0, dram_control_reg};
            ext_bus_pkg::ATTR_OFS: REG_RDATA <= {20'h0, attr_pol_reg};
            ext_bus_pkg::STAT_OFS: REG_RDATA <= {19'h0, lock_reg, cyc_busy, busy_drive_reg,
                                                 arb_reg};
            default:               REG_RDATA <= '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_grant_free;
      ph_end && arb_reg == ARB_WAIT && grant && !busy_ext;
   endsequence

   AST_ADDR_FLOAT: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      !$past(master) |-> A_OE_N) else $error("address driven while slave");
   AST_DATA_FLOAT: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      !$past(active && cur_reg.write) |-> D_OE_N) else $error("data driven idle");
   AST_STB_FLOAT: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      !$past(master) |-> STB_OE_N && BCLK_OE_N) else $error("strobes driven as slave");
   AST_TAKE_BUS: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      s_grant_free |=> master ##1 !BUS_BUSY_N_OUT && !BUS_BUSY_N_OE_N)
      else $error("bus not taken");
   AST_NO_BUSY_TAKE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      ph_end && arb_reg == ARB_WAIT && busy_ext |=> !master)
      else $error("took busy bus");
   AST_RELEASE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      $rose(arb_reg == ARB_RELEASE) |=> BUS_BUSY_N_OUT && !BUS_BUSY_N_OE_N [*4] ##1 BUS_BUSY_N_OE_N)
      else $error("busy release wrong");
   AST_REQ: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      BUS_REQUEST_N == !($past(REQ_VALID) || $past(request_hold_bit)))
      else $error("bus request wrong");
   AST_MIN_WAIT: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      finish |-> wcnt_reg == ws_prog) else $error("cycle ended early");
   AST_ZERO_WAIT: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      ph_end && cyc_busy && first_reg && ws_prog == '0 |-> finish)
      else $error("zero wait stretched");
   AST_STRETCH: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      cyc_busy && ph_end && ws_met && !ack_q_reg && ws_prog != '0 && !dram |-> !finish)
      else $error("ended without ack");
   AST_LOCK: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      lock_hold_bit |=> !BUS_LOCK_N) else $error("lock hold ignored");
   AST_BS_HALF: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      $fell(STB_OUT.bs_n) |=> !STB_OUT.bs_n ##1 STB_OUT.bs_n)
      else $error("bus strobe width");
endmodule

// ### verif/ext_bus_partner.sv
/*
 Far side of the port: bus arbiter, busy pull-up, slow acknowledge and a
 sixteen-word memory. Assumes the bench sets grant_en and ack_stall.
*/
module ext_bus_partner (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 grant_en,
   input  wire logic [7:0]           ack_stall,
   input  wire logic [23:0]          a_out,
   input  wire logic [23:0]          d_out,
   input  wire logic                 d_oe_n,
   input  wire ext_bus_pkg::strobe_t stb,
   input  wire logic                 stb_oe_n,
   input  wire logic                 bb_out,
   input  wire logic                 bb_oe_n,
   output logic [23:0]               d_in,
   output logic                      ack_n,
   output logic                      grant_n,
   output logic                      bb_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] mem [16];
   logic [23:0] last_d;
   logic [9:0]  cnt;
   // ----
   // Arbitration
   // ----
   assign bb_n = bb_oe_n ? 1'h1 : bb_out;
   always_ff @(posedge clk) grant_n <= !grant_en;
   // ----
   // Acknowledge: negated stall core cycles, never used on DRAM
   // ----
   always_ff @(posedge clk) begin
      if (rst || (!stb_oe_n && !stb.bs_n)) cnt <= (rst ? 10'h3FF : 10'h0);
      else if (cnt != 10'h3FF) cnt <= cnt + 10'h1;
   end
   // Pulse is two core cycles wide; a stall of zero ties it low
   assign ack_n = (ack_stall == 8'h0) ? 1'h0 :
      !(cnt >= {ack_stall, 2'h0} && cnt < {ack_stall, 2'h0} + 10'h8);
   // ----
   // Memory; an undriven data bus shows a toggling pattern
   // ----
   always_ff @(posedge clk) begin
      if (!stb_oe_n && !stb.wr_n && !d_oe_n) mem[a_out[3:0]] <= d_out;
      last_d <= rst ? 24'h0 : (d_oe_n ? d_in : d_out);
   end
   assign d_in = (!stb_oe_n && !stb.rd_n) ? mem[a_out[3:0]] : ~last_d;
endmodule

// ### verif/testbench.sv
/*
 Self-checking bench for the external bus port: register port tasks and
 access sequences. Assumes the partner model on the far side.
*/
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 CLOCK, SYS_RST, REG_WR, REG_RD, REQ_VALID, REQ_READY, DONE;
   logic [3:0]           REG_ADDR;
   logic [23:0]          REG_WDATA, REG_RDATA, RDATA, A_OUT, D_IN, D_OUT, rd;
   ext_bus_pkg::req_t    REQ;
   ext_bus_pkg::strobe_t STB_OUT;
   logic                 CORE_CLOCK_OUT, A_OE_N, D_OE_N, STB_OE_N, CAS_OE_N, BCLK, BCLK_OE_N;
   logic                 TRANSFER_ACK_N, BUS_REQUEST_N, BUS_GRANT_N, BUS_BUSY_N_IN;
   logic                 BUS_BUSY_N_OUT, BUS_BUSY_N_OE_N, BUS_LOCK_N, grant_en;
   logic [7:0]           ack_stall;
   int                   fails = 0, tests_run = 0, lat, bs_low, bclk_rise = 0, bb_hi = 0;
   ext_bus_port i_ext_bus_port (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE), .RDATA(RDATA),
      .CORE_CLOCK_OUT(CORE_CLOCK_OUT), .A_OUT(A_OUT), .A_OE_N(A_OE_N), .D_IN(D_IN),
      .D_OUT(D_OUT), .D_OE_N(D_OE_N), .STB_OUT(STB_OUT), .STB_OE_N(STB_OE_N),
      .CAS_OE_N(CAS_OE_N), .BCLK(BCLK), .BCLK_OE_N(BCLK_OE_N),
      .TRANSFER_ACK_N(TRANSFER_ACK_N), .BUS_REQUEST_N(BUS_REQUEST_N),
      .BUS_GRANT_N(BUS_GRANT_N), .BUS_BUSY_N_IN(BUS_BUSY_N_IN),
      .BUS_BUSY_N_OUT(BUS_BUSY_N_OUT), .BUS_BUSY_N_OE_N(BUS_BUSY_N_OE_N),
      .BUS_LOCK_N(BUS_LOCK_N));
   ext_bus_partner i_ext_bus_partner (.clk(CLOCK), .rst(SYS_RST), .grant_en(grant_en),
      .ack_stall(ack_stall), .a_out(A_OUT), .d_out(D_OUT), .d_oe_n(D_OE_N),
      .stb(STB_OUT), .stb_oe_n(STB_OE_N), .bb_out(BUS_BUSY_N_OUT),
      .bb_oe_n(BUS_BUSY_N_OE_N), .d_in(D_IN), .ack_n(TRANSFER_ACK_N),
      .grant_n(BUS_GRANT_N), .bb_n(BUS_BUSY_N_IN));
   initial begin
      CLOCK = 1'h0;
      forever #2.5 CLOCK = ~CLOCK;
   end
   always @(posedge BCLK) if (BCLK_OE_N === 1'h0) bclk_rise++;
   always @(negedge CLOCK) if (BUS_BUSY_N_OE_N === 1'h0 && BUS_BUSY_N_OUT === 1'h1) bb_hi++;
   // ----
   // Checking and closing
   // ----
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ----
   // Register port and bus access
   // ----
   task automatic reg_wr(input logic [3:0] a, input logic [23:0] d);
      @(posedge CLOCK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'h1;
      @(posedge CLOCK);
      REG_WR <= 1'h0;
      repeat (4) @(posedge CLOCK);
   endtask
   task automatic reg_rd(input logic [3:0] a);
      @(posedge CLOCK);
      REG_ADDR <= a;
      REG_RD <= 1'h1;
      @(posedge CLOCK);
      REG_RD <= 1'h0;
      @(negedge CLOCK);
      rd = REG_RDATA;
   endtask
   // Latency counts clocks from the accepting edge to the DONE pulse
   task automatic access(input logic wr, input logic rmw, input ext_bus_pkg::kind_t k,
                         input logic [23:0] d);
      int i;
      @(posedge CLOCK);
      REQ <= '{24'h000003, d, wr, rmw, k, 4'h5};
      REQ_VALID <= 1'h1;
      for (i = 0; i < 400; i++) begin
         @(negedge CLOCK);
         if (REQ_READY === 1'h1) break;
      end
      if (i >= 400) begin
         fails++;
         conclude();
      end
      @(posedge CLOCK);
      REQ_VALID <= 1'h0;
      lat = 0;
      bs_low = 0;
      bclk_rise = 0;
      for (i = 0; i < 400; i++) begin
         @(negedge CLOCK);
         lat++;
         if (STB_OUT.bs_n === 1'h0) bs_low++;
         if (DONE === 1'h1) break;
      end
      if (i >= 400) begin
         fails++;
         conclude();
      end
   endtask
   // ----
   // Scenarios
   // ----
   initial begin
      int ws [2] = '{2, 31};
      int i;
      SYS_RST = 1'h1; REG_WR = 1'h0; REG_RD = 1'h0; REG_ADDR = 4'h0; REG_WDATA = 24'h0;
      REQ_VALID = 1'h0; REQ = '0; grant_en = 1'h1; ack_stall = 8'h0;
      repeat (8) @(posedge CLOCK);
      chk(A_OE_N, 1'h1);
      chk(D_OE_N, 1'h1);
      chk(STB_OE_N, 1'h1);
      chk(BCLK_OE_N, 1'h1);
      chk({BUS_REQUEST_N, BUS_BUSY_N_OE_N, CAS_OE_N}, 3'h7);
      chk(BUS_LOCK_N, 1'h1);
      SYS_RST <= 1'h0;
      repeat (20) @(posedge CLOCK);
      chk(BUS_REQUEST_N, 1'h1);
      chk({BUS_BUSY_N_OE_N, BUS_BUSY_N_OUT}, 2'h0);
      chk(CAS_OE_N, 1'h0);
      lat = 0;
      repeat (4) begin
         @(negedge CLOCK);
         lat += CORE_CLOCK_OUT;
      end
      chk(lat, 2);
      reg_rd(ext_bus_pkg::BCR_OFS);
      chk(rd, 24'h00001F);
      reg_rd(ext_bus_pkg::OMR_OFS);
      chk(rd, 24'h0);
      reg_rd(4'hF);
      chk(rd, 24'h0);
      reg_wr(ext_bus_pkg::ATTR_OFS, 24'h00000F);
      chk(STB_OUT.aa, 4'hF);
      reg_wr(ext_bus_pkg::ATTR_OFS, 24'h0);
      reg_wr(ext_bus_pkg::BCR_OFS, 24'h000020);
      chk(BUS_REQUEST_N, 1'h0);
      reg_wr(ext_bus_pkg::BCR_OFS, 24'h0);
      chk(BUS_REQUEST_N, 1'h1);
      access(1'h1, 1'h0, ext_bus_pkg::K_SRAM, 24'hA5C3F0);
      chk(lat, 5);
      chk(bs_low, 2);
      chk(bclk_rise, 0);
      repeat (4) @(posedge CLOCK);
      chk(D_OE_N, 1'h1);
      chk(A_OUT, 24'h000003);
      chk({BUS_BUSY_N_OE_N, A_OE_N}, 2'h0);
      access(1'h0, 1'h0, ext_bus_pkg::K_SRAM, 24'h0);
      chk(RDATA, 24'hA5C3F0);
      foreach (ws[j]) begin
         reg_wr(ext_bus_pkg::BCR_OFS, ws[j]);
         access(1'h1, 1'h0, ext_bus_pkg::K_SRAM, 24'h123456);
         chk(lat, 4 * (ws[j] + 1) + 1);
      end
      reg_wr(ext_bus_pkg::BCR_OFS, 24'h000001);
      ack_stall <= 8'h8;
      for (i = 0; i < 2; i++) begin
         reg_wr(ext_bus_pkg::OMR_OFS, i);
         access(1'h1, 1'h0, ext_bus_pkg::K_SRAM, 24'h0F0F0F);
         chk(lat >= 33 && lat <= 49, 1'h1);
      end
      ack_stall <= 8'h0;
      reg_wr(ext_bus_pkg::OMR_OFS, 24'h0);
      access(1'h1, 1'h0, ext_bus_pkg::K_DRAM, 24'h000DDD);
      chk(lat, 9);
      reg_wr(ext_bus_pkg::BCR_OFS, 24'h0);
      access(1'h1, 1'h0, ext_bus_pkg::K_SSRAM, 24'h000777);
      chk(bclk_rise != 0, 1'h1);
      access(1'h0, 1'h1, ext_bus_pkg::K_SRAM, 24'h0);
      chk(BUS_LOCK_N, 1'h0);
      access(1'h1, 1'h1, ext_bus_pkg::K_SRAM, 24'h000001);
      repeat (2) @(negedge CLOCK);
      chk(BUS_LOCK_N, 1'h1);
      reg_wr(ext_bus_pkg::BCR_OFS, 24'h000040);
      chk(BUS_LOCK_N, 1'h0);
      reg_wr(ext_bus_pkg::BCR_OFS, 24'h0);
      grant_en <= 1'h0;
      for (i = 0; i < 100 && BUS_BUSY_N_OE_N !== 1'h1; i++) @(negedge CLOCK);
      if (BUS_BUSY_N_OE_N !== 1'h1) begin
         fails++;
         conclude();
      end
      chk(bb_hi != 0, 1'h1);
      chk({A_OE_N, STB_OE_N, CAS_OE_N}, 3'h7);
      reg_wr(ext_bus_pkg::DCR_OFS, 24'h000001);
      chk(CAS_OE_N, 1'h0);
      conclude();
   end
endmodule
